/* File: verilog/uart_interrupt_mask.sv */
/*
 * Interrupt mask, raw status, masked status and clear registers of the
 * serial port, reached over an Avalon-MM slave with waitrequest.
 * Assumes the serial-port core pulses EVENT_IN for one cycle per event,
 * synchronous to CLK, and that the bus master holds a request until it
 * sees waitrequest low.
 */
`timescale 1ns/1ps
`include "uart_intmask_defs.svh"

module uart_interrupt_mask #(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input  wire logic              CLK,
	input  wire logic              RST_B,
	// Avalon-MM slave
	input  wire logic [ADDR_W-1:0] AVS_ADDRESS,
	input  wire logic              AVS_READ,
	input  wire logic              AVS_WRITE,
	input  wire logic [31:0]       AVS_WRITEDATA,
	input  wire logic [3:0]        AVS_BYTEENABLE,
	output logic      [31:0]       AVS_READDATA,
	output logic                   AVS_WAITREQUEST,
	// Event pulses from the serial-port core
	input  wire logic [12:0]       EVENT_IN,
	// Interrupt line to the processor
	output logic                   IRQ
);

	// ----------------------------------------------------------------
	// Bus request capture
	// ----------------------------------------------------------------
	uart_intmask_pkg::bus_req_t   bus;
	uart_intmask_pkg::bus_state_t state_reg;
	uart_intmask_pkg::bus_state_t state_next;
	uart_intmask_pkg::src_vec_t   mask_reg;
	uart_intmask_pkg::src_vec_t   mask_next;
	uart_intmask_pkg::src_vec_t   raw_reg;
	uart_intmask_pkg::src_vec_t   raw_next;
	uart_intmask_pkg::src_vec_t   masked;
	uart_intmask_pkg::src_vec_t   events;
	uart_intmask_pkg::src_vec_t   clear_vec;
	logic [31:0]                  rdata_reg;
	logic [31:0]                  rdata_next;
	logic [31:0]                  wmerge_mask;
	logic [31:0]                  wmerge_clear;
	logic                         take;
	logic                         take_wr;
	logic                         take_rd;

	// Bundle the Avalon signals; upper address bits are not decoded
	assign bus = '{
		read:       AVS_READ,
		write:      AVS_WRITE,
		address:    AVS_ADDRESS[7:0],
		writedata:  AVS_WRITEDATA,
		byteenable: AVS_BYTEENABLE
	};

	// ----------------------------------------------------------------
	// Byte-lane helper
	// ----------------------------------------------------------------
	// Keeps old bytes where the lane is not enabled
	function automatic logic [31:0] lane_merge(
		input logic [31:0] old_val,
		input logic [31:0] new_val,
		input logic [3:0]  be
	);
		logic [31:0] res;
		res = old_val;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = new_val[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// ----------------------------------------------------------------
	// Answer sequencer
	// ----------------------------------------------------------------
	// One wait cycle lets read data come from a flop, not a mux
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			uart_intmask_pkg::BUS_IDLE: begin
				if (bus.read || bus.write) begin
					state_next = uart_intmask_pkg::BUS_ANSWER;
				end
			end
			uart_intmask_pkg::BUS_ANSWER: begin
				state_next = uart_intmask_pkg::BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			state_reg <= uart_intmask_pkg::BUS_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Waitrequest drops only in the answer cycle
	assign AVS_WAITREQUEST = (bus.read || bus.write) &&
		(state_reg != uart_intmask_pkg::BUS_ANSWER);
	assign take    = state_reg == uart_intmask_pkg::BUS_ANSWER;
	assign take_wr = take && bus.write;
	assign take_rd = take && bus.read;

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	// Loaded while waiting so it stands at the taking edge
	always_comb begin
		rdata_next = rdata_reg;
		if (state_reg == uart_intmask_pkg::BUS_IDLE && bus.read) begin
			unique case (bus.address)
				`IEM_OFFSET:    rdata_next = {19'h0, mask_reg};
				`RAW_OFFSET:    rdata_next = {19'h0, raw_reg};
				`MASKED_OFFSET: rdata_next = {19'h0, masked};
				default:        rdata_next = 32'h0000_0000;      // Unmapped and clear reg
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			rdata_reg <= `READDATA_RESET;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	assign AVS_READDATA = rdata_reg;

	// ----------------------------------------------------------------
	// Enable mask
	// ----------------------------------------------------------------
	// Only source positions are stored; reserved bits stay zero
	assign wmerge_mask = lane_merge({19'h0, mask_reg}, bus.writedata, bus.byteenable);

	always_comb begin
		mask_next = mask_reg;
		if (take_wr && bus.address == `IEM_OFFSET) begin
			mask_next = wmerge_mask[`SRC_WIDTH-1:0] & `SRC_BITS_MASK;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			mask_reg <= `IEM_RESET;
		end else begin
			mask_reg <= mask_next;
		end
	end

	// ----------------------------------------------------------------
	// Raw status
	// ----------------------------------------------------------------
	// Clear by writing ones to the clear register, or by reading raw status
	assign wmerge_clear = lane_merge(32'h0000_0000, bus.writedata, bus.byteenable);
	assign events       = EVENT_IN & `SRC_BITS_MASK;

	always_comb begin
		clear_vec = '0;
		if (take_wr && bus.address == `CLEAR_OFFSET) begin
			clear_vec = wmerge_clear[`SRC_WIDTH-1:0];
		end else if (take_rd && bus.address == `RAW_OFFSET) begin
			clear_vec = rdata_reg[`SRC_WIDTH-1:0];
		end
		// A new event in the clearing cycle wins over the clear
		raw_next = (raw_reg & ~clear_vec) | events;
	end

	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			raw_reg <= `RAW_RESET;
		end else begin
			raw_reg <= raw_next;
		end
	end

	// ----------------------------------------------------------------
	// Masked status and interrupt line
	// ----------------------------------------------------------------
	// Both operands are flops, so the line is glitch-free enough for a level
	assign masked = raw_reg & mask_reg;
	assign IRQ    = |masked;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);

	logic take_iem;
	assign take_iem = take_wr && bus.address == `IEM_OFFSET;

	cts_enable_a: assert property (take_iem && bus.byteenable[0] |=>
		mask_reg[`CTS_CHANGE_BIT] == $past(bus.writedata[`CTS_CHANGE_BIT]))
		else $error("cts change enable not written");
	rx_enable_a: assert property (take_iem && bus.byteenable[0] |=>
		mask_reg[`RECEIVE_BIT] == $past(bus.writedata[`RECEIVE_BIT]))
		else $error("receive enable not written");
	tx_enable_a: assert property (take_iem && bus.byteenable[0] |=>
		mask_reg[`TRANSMIT_BIT] == $past(bus.writedata[`TRANSMIT_BIT]))
		else $error("transmit enable not written");
	rx_timeout_enable_a: assert property (take_iem && bus.byteenable[0] |=>
		mask_reg[`RECEIVE_TIMEOUT_BIT] == $past(bus.writedata[`RECEIVE_TIMEOUT_BIT]))
		else $error("receive timeout enable not written");
	framing_enable_a: assert property (take_iem && bus.byteenable[0] |=>
		mask_reg[`FRAMING_ERROR_BIT] == $past(bus.writedata[`FRAMING_ERROR_BIT]))
		else $error("framing error enable not written");
	parity_enable_a: assert property (take_iem && bus.byteenable[1] |=>
		mask_reg[`PARITY_ERROR_BIT] == $past(bus.writedata[`PARITY_ERROR_BIT]))
		else $error("parity error enable not written");
	break_enable_a: assert property (take_iem && bus.byteenable[1] |=>
		mask_reg[`BREAK_ERROR_BIT] == $past(bus.writedata[`BREAK_ERROR_BIT]))
		else $error("break error enable not written");
	overrun_enable_a: assert property (take_iem && bus.byteenable[1] |=>
		mask_reg[`OVERRUN_ERROR_BIT] == $past(bus.writedata[`OVERRUN_ERROR_BIT]))
		else $error("overrun error enable not written");
	flow_stop_enable_a: assert property (take_iem && bus.byteenable[1] |=>
		mask_reg[`FLOW_STOP_CHAR_BIT] == $past(bus.writedata[`FLOW_STOP_CHAR_BIT]))
		else $error("flow stop enable not written");
	fifo_empty_enable_a: assert property (take_iem && bus.byteenable[1] |=>
		mask_reg[`TX_FIFO_EMPTY_BIT] == $past(bus.writedata[`TX_FIFO_EMPTY_BIT]))
		else $error("fifo empty enable not written");

	// Read data at the taking edge carries the mask held then
	mask_readback_a: assert property (take_rd && bus.address == `IEM_OFFSET |->
		AVS_READDATA == {19'h0, mask_reg})
		else $error("mask read does not match held mask");

	// Reset leaves every source disabled and the line low; looked at on the
	// first edge after release, since the disable term masks the reset cycles
	reset_disable_a: assert property ($rose(RST_B) |->
		mask_reg == '0 && raw_reg == '0 && !IRQ)
		else $error("mask not cleared by reset");

	// Masked status read agrees with raw and enable
	masked_read_a: assert property (take_rd && bus.address == `MASKED_OFFSET |->
		AVS_READDATA == {19'h0, $past(raw_reg) & $past(mask_reg)})
		else $error("masked status read wrong");

	// A clear with no new event empties the bit next cycle
	clear_write_a: assert property (take_wr && bus.address == `CLEAR_OFFSET &&
		bus.byteenable[0] && bus.writedata[`RECEIVE_BIT] && !EVENT_IN[`RECEIVE_BIT]
		|=> !raw_reg[`RECEIVE_BIT])
		else $error("clear write did not clear receive status");
	set_wins_a: assert property (EVENT_IN[`RECEIVE_BIT] |=> raw_reg[`RECEIVE_BIT])
		else $error("event lost against clear");

	// A zero in the clear word leaves a pending source alone
	clear_zero_a: assert property (take_wr && bus.address == `CLEAR_OFFSET &&
		bus.byteenable[0] && !bus.writedata[`RECEIVE_BIT] && raw_reg[`RECEIVE_BIT]
		|=> raw_reg[`RECEIVE_BIT])
		else $error("zero in clear word dropped a pending source");

	// Reading raw status drops exactly what that read returned
	raw_read_clear_a: assert property (take_rd && bus.address == `RAW_OFFSET &&
		AVS_READDATA[`RECEIVE_BIT] && !EVENT_IN[`RECEIVE_BIT]
		|=> !raw_reg[`RECEIVE_BIT])
		else $error("raw status read did not clear receive status");

	// Reserved positions never hold a one
	reserved_zero_a: assert property (take_rd |->
		AVS_READDATA[31:13] == 19'h0 && AVS_READDATA[0] == 1'b0 &&
		AVS_READDATA[3:2] == 2'b00)
		else $error("reserved bits read nonzero");

	// An enabled event raises the line on the next edge
	irq_raise_a: assert property (EVENT_IN[`RECEIVE_BIT] && mask_reg[`RECEIVE_BIT] &&
		!take_iem |=> IRQ)
		else $error("enabled event did not raise the interrupt line");

	// Disabling every source drops the line one cycle later
	irq_off_a: assert property (take_iem && bus.byteenable[1:0] == 2'b11 &&
		bus.writedata[12:0] == 13'h0000 |=> !IRQ)
		else $error("interrupt line high with all sources disabled");

	// Every request is answered one cycle after it rises
	answer_time_a: assert property ($rose(bus.read || bus.write) |-> AVS_WAITREQUEST ##1
		!AVS_WAITREQUEST)
		else $error("bus answer late");

endmodule // uart_interrupt_mask

/* File: common/uart_intmask_defs.svh */
/*
 * Offsets, bit positions, reset values and widths of the serial-port
 * interrupt mask block. Assumes byte addressing on a 32-bit register bus.
 */
`ifndef UART_INTMASK_DEFS_SVH
`define UART_INTMASK_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses from the serial port base)
// ----------------------------------------------------------------
`define IEM_OFFSET    8'h38
`define RAW_OFFSET    8'h3c
`define MASKED_OFFSET 8'h40
`define CLEAR_OFFSET  8'h44

// ----------------------------------------------------------------
// Source bit positions, shared by mask, status and clear registers
// ----------------------------------------------------------------
`define CTS_CHANGE_BIT      1
`define RECEIVE_BIT         4
`define TRANSMIT_BIT        5
`define RECEIVE_TIMEOUT_BIT 6
`define FRAMING_ERROR_BIT   7
`define PARITY_ERROR_BIT    8
`define BREAK_ERROR_BIT     9
`define OVERRUN_ERROR_BIT   10
`define FLOW_STOP_CHAR_BIT  11
`define TX_FIFO_EMPTY_BIT   12

// ----------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------
`define SRC_WIDTH       13
`define SRC_BITS_MASK   13'h1ff2
`define IEM_RESET       13'h0000
`define RAW_RESET       13'h0000
`define READDATA_RESET  32'h0000_0000

`endif

/* File: common/uart_intmask_pkg.sv */
/*
 * Types of the serial-port interrupt mask block.
 * Assumes the constants header is on the include path.
 */
`include "uart_intmask_defs.svh"

package uart_intmask_pkg;

	// One vector bit per interrupt source position
	typedef logic [`SRC_WIDTH-1:0] src_vec_t;

	// Avalon-MM request as seen by the slave
	typedef struct packed {
		logic        read;
		logic        write;
		logic [7:0]  address;
		logic [31:0] writedata;
		logic [3:0]  byteenable;
	} bus_req_t;

	// Bus answer sequencer
	typedef enum logic {
		BUS_IDLE   = 1'b0,
		BUS_ANSWER = 1'b1
	} bus_state_t;

endpackage

/* File: sim/tb_top.sv */
/*
 * Self-checking bench of the serial-port interrupt mask block.
 * Assumes the design's constants header is on the include path and that
 * the block answers each bus request within 20 cycles.
 */
`timescale 1ns/1ps
`include "uart_intmask_defs.svh"

module tb_top;

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic        CLK;
	logic        RST_B;
	logic [7:0]  AVS_ADDRESS;
	logic        AVS_READ;
	logic        AVS_WRITE;
	logic [31:0] AVS_WRITEDATA;
	logic [3:0]  AVS_BYTEENABLE;
	logic [31:0] AVS_READDATA;
	logic        AVS_WAITREQUEST;
	logic [12:0] EVENT_IN;
	logic        IRQ;
	int          n_errors;
	int          comparisons;
	logic [31:0] q;

	// Mask write values beside the readback they should give
	localparam logic [31:0] WDAT [13] = '{32'h2, 32'h10, 32'h20, 32'h40, 32'h80,
		32'h100, 32'h200, 32'h400, 32'h800, 32'h1000, 32'hffffffff, 32'hd, 32'hffffe000};
	localparam logic [31:0] EXP [13] = '{32'h2, 32'h10, 32'h20, 32'h40, 32'h80,
		32'h100, 32'h200, 32'h400, 32'h800, 32'h1000, 32'h1ff2, 32'h0, 32'h0};

	uart_interrupt_mask u_dut (
		.CLK             (CLK),
		.RST_B           (RST_B),
		.AVS_ADDRESS     (AVS_ADDRESS),
		.AVS_READ        (AVS_READ),
		.AVS_WRITE       (AVS_WRITE),
		.AVS_WRITEDATA   (AVS_WRITEDATA),
		.AVS_BYTEENABLE  (AVS_BYTEENABLE),
		.AVS_READDATA    (AVS_READDATA),
		.AVS_WAITREQUEST (AVS_WAITREQUEST),
		.EVENT_IN        (EVENT_IN),
		.IRQ             (IRQ)
	);

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic end_sim;
		if (n_errors == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One bus access; waitrequest and read data are taken at the same rising edge
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] be, output logic [31:0] rd);
		bit done;
		done = 0;
		rd = 32'h0;
		@(posedge CLK);
		AVS_READ <= !wr;
		AVS_WRITE <= wr;
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= d;
		AVS_BYTEENABLE <= be;
		for (int i = 0; i < 20 && !done; i++) begin
			@(posedge CLK);
			if (AVS_WAITREQUEST === 1'b0) begin
				done = 1;
				rd = AVS_READDATA;
			end
		end
		if (!done) begin
			n_errors++;
			end_sim();
		end
		// Release right after the taking edge
		AVS_READ <= 1'b0;
		AVS_WRITE <= 1'b0;
	endtask

	// One-cycle event pulse, then wait for the falling edge so the line has settled
	task automatic pulse(input logic [12:0] v);
		@(posedge CLK);
		EVENT_IN <= v;
		@(posedge CLK);
		EVENT_IN <= 13'h0;
		@(negedge CLK);
	endtask

	task automatic irq_is(input logic e);
		@(negedge CLK);
		check({31'h0, IRQ}, {31'h0, e});
	endtask

	// ----------------------------------------------------------------
	// Clock and sequence
	// ----------------------------------------------------------------
	initial begin
		CLK = 1'b0;
		forever #20 CLK = ~CLK;
	end

	initial begin
		RST_B = 1'b0;
		AVS_ADDRESS = 8'h0;
		AVS_READ = 1'b0;
		AVS_WRITE = 1'b0;
		AVS_WRITEDATA = 32'h0;
		AVS_BYTEENABLE = 4'hf;
		EVENT_IN = 13'h0;
		n_errors = 0;
		comparisons = 0;
		repeat (20) @(posedge CLK);
		RST_B <= 1'b1;
		// Every row: write mask, read it back, fire all sources, clear them
		for (int r = 0; r < 13; r++) begin
			bus(1'b1, `IEM_OFFSET, WDAT[r], 4'hf, q);
			bus(1'b0, `IEM_OFFSET, 32'h0, 4'hf, q);
			check(q, EXP[r]);
			pulse(13'h1fff);
			check({31'h0, IRQ}, {31'h0, |EXP[r]});
			bus(1'b0, `MASKED_OFFSET, 32'h0, 4'hf, q);
			check(q, EXP[r]);
			bus(1'b1, `CLEAR_OFFSET, 32'h1fff, 4'hf, q);
			irq_is(1'b0);
			bus(1'b0, `RAW_OFFSET, 32'h0, 4'hf, q);
			check(q, 32'h0);
		end
		// Only lane 0 of the write reaches the mask
		bus(1'b1, `IEM_OFFSET, 32'h1ff2, 4'h1, q);
		bus(1'b0, `IEM_OFFSET, 32'h0, 4'hf, q);
		check(q, 32'hf2);
		// Zeros in the clear word leave a pending source alone
		pulse(13'h0010);
		bus(1'b1, `CLEAR_OFFSET, 32'hffffffef, 4'hf, q);
		irq_is(1'b1);
		bus(1'b0, `RAW_OFFSET, 32'h0, 4'hf, q);
		check(q, 32'h10);
		irq_is(1'b0);
		// Unmapped place and the write-only clear word read zero
		bus(1'b1, 8'h10, 32'hffffffff, 4'hf, q);
		bus(1'b0, 8'h10, 32'h0, 4'hf, q);
		check(q, 32'h0);
		bus(1'b0, `CLEAR_OFFSET, 32'h0, 4'hf, q);
		check(q, 32'h0);
		bus(1'b0, `IEM_OFFSET, 32'h0, 4'hf, q);
		check(q, 32'hf2);
		// Reset in mid-run while an interrupt is pending
		pulse(13'h0010);
		check({31'h0, IRQ}, 32'h1);
		@(posedge CLK);
		RST_B <= 1'b0;
		repeat (2) @(posedge CLK);
		RST_B <= 1'b1;
		irq_is(1'b0);
		bus(1'b0, `IEM_OFFSET, 32'h0, 4'hf, q);
		check(q, 32'h0);
		// With no request pending the slave must not stall the bus
		@(negedge CLK);
		check({31'h0, AVS_WAITREQUEST}, 32'h0);
		end_sim();
	end

endmodule // tb_top
